// ### sim/pgm_host_model.sv
// serial controller model standing in for the host processor
`timescale 1ns/10ps
module pgm_host_model (
  // clock
  input  wire logic sys_clk,
  // serial lines
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaPull
);
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  // 4-clock phases keep well above the 2-clock minimum the target needs to see a level
  task automatic half(input logic scl, input logic pull);
    @(posedge sys_clk);
    sclOut <= scl;
    sdaPull <= pull;
    repeat (3) @(posedge sys_clk);
  endtask
  // clock low with data released first, so that a repeated start also
  // follows an ack cleanly; then data falls while the clock is high
  task automatic start();
    half(1'b0, 1'b0);
    half(1'b1, 1'b0);
    half(1'b1, 1'b1);
    half(1'b0, 1'b1);
  endtask
  // data rises while the clock is high
  task automatic stop();
    half(1'b0, 1'b1);
    half(1'b1, 1'b1);
    half(1'b1, 1'b0);
  endtask
  // nine bits msb first, a one releases the line; q holds what the line showed
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      half(1'b0, !d[i]);
      half(1'b1, !d[i]);
      q[i] = sdaLine;
    end
  endtask
endmodule

// ### sim/pgm_mask_checker.sv
// assertions on the mask register block ports
`timescale 1ns/10ps
module pgm_mask_checker
  import pgm_pkg::*;
#(
  parameter pgm_variant_type VARIANT = VARIANT_A
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // serial port
  input wire logic       sclIn,
  input wire logic       sdaOe,
  // pins and rails
  input wire logic       controlInputOne,
  input wire logic       controlInputTwo,
  input wire logic       controlInputFour,
  input wire logic       controlInputFive,
  input wire logic       terminationRegulatorPg,
  input wire logic       bLoadSwitchOnePg,
  input wire logic       bLoadSwitchTwoPg,
  input wire logic       aLinearRegOnePg,
  input wire logic       aLinearRegTwoPg,
  input wire logic       aLinearRegThreePg,
  input wire logic       aLoadSwitchOnePg,
  input wire logic       stepDownOnePg,
  input wire logic       stepDownTwoPg,
  input wire logic       stepDownThreePg,
  input wire logic       stepDownFourPg,
  input wire logic       stepDownFivePg,
  input wire logic       stepDownSixPg,
  // results
  input wire logic       generalOutputOneGood,
  input wire logic       generalOutputFourGood,
  input wire logic [7:0] outOneMask,
  input wire logic [7:0] outFourMask
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // only variant D feeds the second b-rail switch into the shared slot
  wire logic       sharedPg = (VARIANT == VARIANT_D) ? bLoadSwitchTwoPg : aLinearRegOnePg;
  wire logic [7:0] oneIn    = {controlInputFive, controlInputFour, controlInputTwo,
    controlInputOne, terminationRegulatorPg, sharedPg, bLoadSwitchOnePg, aLinearRegThreePg};
  wire logic [7:0] fourIn   = {aLinearRegTwoPg, aLoadSwitchOnePg, stepDownSixPg, stepDownFivePg,
    stepDownFourPg, stepDownThreePg, stepDownTwoPg, stepDownOnePg};
  property p_one_tree;
    !$past(sys_rst) |-> generalOutputOneGood == &($past(oneIn) | $past(outOneMask));
  endproperty
  a_one_tree: assert property (p_one_tree) else $error("output one wrong");
  property p_four_tree;
    !$past(sys_rst) |-> generalOutputFourGood == &($past(fourIn) | $past(outFourMask));
  endproperty
  a_four_tree: assert property (p_four_tree) else $error("output four wrong");
  property p_ctrl_five;
    !controlInputFive && !outOneMask[7] |=> !generalOutputOneGood;
  endproperty
  a_ctrl_five: assert property (p_ctrl_five) else $error("pin five not used");
  property p_shared;
    !sharedPg && !outOneMask[2] |=> !generalOutputOneGood;
  endproperty
  a_shared: assert property (p_shared) else $error("shared input not used");
  property p_step_one;
    !stepDownOnePg && !outFourMask[0] |=> !generalOutputFourGood;
  endproperty
  a_step_one: assert property (p_step_one) else $error("step-down one not used");
  property p_four_open;
    outFourMask == 8'hFF |=> generalOutputFourGood;
  endproperty
  a_four_open: assert property (p_four_open) else $error("masked input counted");
  property p_defaults;
    $fell(sys_rst) |-> outOneMask == pgm_out1_reset(VARIANT)
      && outFourMask == pgm_out4_reset(VARIANT);
  endproperty
  a_defaults: assert property (p_defaults) else $error("mask reset value wrong");
  // a mask only moves where a serial clock fall has just been seen
  property p_write_edge;
    $changed({outOneMask, outFourMask}) |-> $past(sclIn, 2) && !$past(sclIn);
  endproperty
  a_write_edge: assert property (p_write_edge) else $error("mask moved off edge");
  property p_drive_low;
    $rose(sdaOe) |-> !$past(sclIn) && $past(sclIn, 2);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data not moved after clock fall");
  c_write: cover property ($changed(outOneMask));
  c_four_good: cover property ($rose(generalOutputFourGood));
  c_ack: cover property ($rose(sdaOe));
endmodule
bind pgm_mask_top pgm_mask_checker #(.VARIANT(VARIANT)) u_pgm_mask_checker (.*);

// ### sim/tb_pgm_mask_top.sv
// testbench for the power-good mask register block
`timescale 1ns/10ps
module tb_pgm_mask_top
  import pgm_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] oneVec = 8'hFF;
  logic [7:0] fourVec = 8'hFF;
  logic       bSwitchTwo = 1'b1;
  logic       sclIn;
  logic       hostPull;
  logic       sdaOut;
  logic       sdaOe;
  logic       oneGood;
  logic       fourGood;
  logic [7:0] outOneMask;
  logic [7:0] outFourMask;
  int         err_count = 0;
  int         comparisons = 0;
  // pulled-up data line, low while either side pulls
  wire logic  sdaLine = !(hostPull || (sdaOe && !sdaOut));
  always #20 sys_clk = !sys_clk;
  pgm_mask_top u_pgm_mask_top (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe),
    .controlInputOne(oneVec[4]), .controlInputTwo(oneVec[5]),
    .controlInputFour(oneVec[6]), .controlInputFive(oneVec[7]),
    .terminationRegulatorPg(oneVec[3]), .bLoadSwitchOnePg(oneVec[1]),
    .bLoadSwitchTwoPg(bSwitchTwo), .aLinearRegOnePg(oneVec[2]),
    .aLinearRegTwoPg(fourVec[7]), .aLinearRegThreePg(oneVec[0]),
    .aLoadSwitchOnePg(fourVec[6]), .stepDownOnePg(fourVec[0]),
    .stepDownTwoPg(fourVec[1]), .stepDownThreePg(fourVec[2]),
    .stepDownFourPg(fourVec[3]), .stepDownFivePg(fourVec[4]), .stepDownSixPg(fourVec[5]),
    .generalOutputOneGood(oneGood), .generalOutputFourGood(fourGood),
    .outOneMask(outOneMask), .outFourMask(outFourMask)
  );
  pgm_host_model u_pgm_host_model (
    .sys_clk(sys_clk), .sdaLine(sdaLine), .sclOut(sclIn), .sdaPull(hostPull)
  );
  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] dat);
    logic [8:0] q;
    u_pgm_host_model.start();
    u_pgm_host_model.xfer({DEV_ADDR_DEFAULT, 2'b01}, q);
    u_pgm_host_model.xfer({off, 1'b1}, q);
    u_pgm_host_model.xfer({dat, 1'b1}, q);
    u_pgm_host_model.stop();
  endtask
  // offset write, repeated start, then one or two bytes read; the last one is refused
  task automatic rd(input logic [7:0] off, input logic two, output logic [15:0] dat);
    logic [8:0] q;
    u_pgm_host_model.start();
    u_pgm_host_model.xfer({DEV_ADDR_DEFAULT, 2'b01}, q);
    u_pgm_host_model.xfer({off, 1'b1}, q);
    u_pgm_host_model.start();
    u_pgm_host_model.xfer({DEV_ADDR_DEFAULT, 2'b11}, q);
    u_pgm_host_model.xfer({8'hFF, !two}, q);
    dat[15:8] = q[8:1];
    if (two) begin
      u_pgm_host_model.xfer(9'h1FF, q);
      dat[7:0] = q[8:1];
    end
    u_pgm_host_model.stop();
  endtask
  // rail inputs move on a clock edge; results are looked at two edges later
  task automatic apply(input logic [7:0] v1, input logic [7:0] v4);
    @(posedge sys_clk);
    oneVec <= v1;
    fourVec <= v4;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  function automatic logic good(input logic sel);
    return sel ? fourGood : oneGood;
  endfunction
  // bit i masked while its input fails, then its neighbour failing unmasked
  task automatic t_tree(input logic sel);
    logic [7:0] m;
    logic [7:0] off;
    off = sel ? OUT4_MASK_LO_ADDR : OUT1_MASK_HI_ADDR;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(off, m);
      apply(sel ? 8'hFF : ~m, sel ? ~m : 8'hFF);
      check({7'h00, good(sel)}, 8'h01);
      m = 8'h01 << ((i + 1) % 8);
      apply(sel ? 8'hFF : ~m, sel ? ~m : 8'hFF);
      check({7'h00, good(sel)}, 8'h00);
    end
  endtask
  // variant A takes the a-rail regulator one, not the b-rail switch two
  task automatic t_shared();
    wr(OUT1_MASK_HI_ADDR, 8'h00);
    @(posedge sys_clk);
    bSwitchTwo <= 1'b0;
    apply(8'hFF, 8'hFF);
    check({7'h00, oneGood}, 8'h01);
    apply(8'hFB, 8'hFF);
    check({7'h00, oneGood}, 8'h00);
  endtask
  task automatic t_regs();
    logic [8:0]  q;
    logic [15:0] d;
    check(outOneMask, 8'hFF);
    check(outFourMask, 8'hF7);
    rd(OUT1_MASK_HI_ADDR, 1'b1, d);
    check(d[15:8], 8'hFF);
    check(d[7:0], 8'hF7);
    u_pgm_host_model.start();
    u_pgm_host_model.xfer({DEV_ADDR_DEFAULT, 2'b01}, q);
    u_pgm_host_model.xfer({OUT1_MASK_HI_ADDR, 1'b1}, q);
    u_pgm_host_model.xfer({8'h3C, 1'b1}, q);
    u_pgm_host_model.xfer({8'hFF, 1'b1}, q);
    u_pgm_host_model.stop();
    rd(OUT1_MASK_HI_ADDR, 1'b1, d);
    check(d[15:8], 8'h3C);
    check(d[7:0], 8'hFF);
    check(outFourMask, 8'hFF);
    // another target address must be left alone
    u_pgm_host_model.start();
    u_pgm_host_model.xfer({~DEV_ADDR_DEFAULT, 2'b01}, q);
    check({7'h00, q[0]}, 8'h01);
    u_pgm_host_model.xfer({OUT1_MASK_HI_ADDR, 1'b1}, q);
    u_pgm_host_model.xfer({8'h00, 1'b1}, q);
    u_pgm_host_model.stop();
    wr(8'h10, 8'h55);
    check(outOneMask, 8'h3C);
    rd(8'h10, 1'b0, d);
    check(d[15:8], UNMAPPED_DATA);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check(outOneMask, 8'hFF);
    check(outFourMask, 8'hF7);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_tree(1'b0);
    t_tree(1'b1);
    t_shared();
    wrap_up();
  end
  // the whole sequence needs about 6000 clocks
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule

// ### src/pgm_mask_regs.sv
// the two power-good mask registers with variant reset and read mux
`timescale 1ns/10ps
module pgm_mask_regs
  import pgm_pkg::*;
#(
  parameter logic [7:0] OUT1_RESET = OUT1_RST_A,
  parameter logic [7:0] OUT4_RESET = OUT4_RST_A
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // write and read access
  input  wire logic       wrEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData,
  // mask values
  output logic      [7:0] outOneMask,
  output logic      [7:0] outFourMask
);

  logic [7:0] next_outOneMask;
  logic [7:0] next_outFourMask;

  always_comb begin
    next_outOneMask  = outOneMask;
    next_outFourMask = outFourMask;
    if (wrEn && regAddr == OUT1_MASK_HI_ADDR) begin
      next_outOneMask = wrData; // [RULE_18]
    end else if (wrEn && regAddr == OUT4_MASK_LO_ADDR) begin
      next_outFourMask = wrData; // [RULE_18]
    end
    if (regAddr == OUT1_MASK_HI_ADDR) begin
      rdData = outOneMask;
    end else if (regAddr == OUT4_MASK_LO_ADDR) begin
      rdData = outFourMask;
    end else begin
      rdData = UNMAPPED_DATA;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outOneMask  <= OUT1_RESET; // [RULE_18]
      outFourMask <= OUT4_RESET; // [RULE_18]
    end else begin
      outOneMask  <= next_outOneMask;
      outFourMask <= next_outFourMask;
    end
  end

endmodule

// ### src/pgm_mask_top.sv
// serial register port, mask registers and the two power-good combinations
`timescale 1ns/10ps
// Contract
// [RULE_01] Output one includes control input five unless mask bit 7 is set.
// [RULE_02] Output one includes control input four unless mask bit 6 is set.
// [RULE_03] Output one includes control input two unless mask bit 5 is set.
// [RULE_04] Output one includes control input one unless mask bit 4 is set.
// [RULE_05] Output one includes termination regulator good unless mask bit 3 is set.
// [RULE_06] Mask bit 2 gates the shared rail, chosen by factory variant.
// [RULE_07] Output one includes b-rail switch one good unless mask bit 1 is set.
// [RULE_08] Output one includes a-rail regulator three good unless mask bit 0 set.
// [RULE_09] Output four includes a-rail regulator two good unless bit 7 set.
// [RULE_10] Output four includes a-rail switch one good unless bit 6 set.
// [RULE_11] Output four includes step-down six good unless bit 5 set.
// [RULE_12] Output four includes step-down five good unless bit 4 set.
// [RULE_13] Output four includes step-down four good unless bit 3 set.
// [RULE_14] Output four includes step-down three good unless bit 2 set.
// [RULE_15] Output four includes step-down two good unless bit 1 set.
// [RULE_16] Output four includes step-down one good unless bit 0 set.
// [RULE_17] An output is good only when all unmasked inputs are good.
// [RULE_18] Masks reset to variant defaults, are read/write, act at once.
module pgm_mask_top
  import pgm_pkg::*;
#(
  parameter pgm_variant_type VARIANT  = VARIANT_A,
  parameter logic [6:0]      DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // serial control port, data line open drain
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // control input pin states
  input  wire logic       controlInputOne,
  input  wire logic       controlInputTwo,
  input  wire logic       controlInputFour,
  input  wire logic       controlInputFive,
  // rail power-good inputs
  input  wire logic       terminationRegulatorPg,
  input  wire logic       bLoadSwitchOnePg,
  input  wire logic       bLoadSwitchTwoPg,
  input  wire logic       aLinearRegOnePg,
  input  wire logic       aLinearRegTwoPg,
  input  wire logic       aLinearRegThreePg,
  input  wire logic       aLoadSwitchOnePg,
  input  wire logic       stepDownOnePg,
  input  wire logic       stepDownTwoPg,
  input  wire logic       stepDownThreePg,
  input  wire logic       stepDownFourPg,
  input  wire logic       stepDownFivePg,
  input  wire logic       stepDownSixPg,
  // combined power-good results
  output logic            generalOutputOneGood,
  output logic            generalOutputFourGood,
  // current mask settings
  output logic      [7:0] outOneMask,
  output logic      [7:0] outFourMask
);

  pgm_i2c_state_type state;
  pgm_i2c_state_type next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] rxShift;
  logic [7:0] next_rxShift;
  logic [7:0] txShift;
  logic [7:0] next_txShift;
  logic [7:0] regPtr;
  logic [7:0] next_regPtr;
  logic       sdaDrive;
  logic       next_sdaDrive;
  logic       masterAck;
  logic       next_masterAck;
  logic       sclPrev;
  logic       next_sclPrev;
  logic       sdaPrev;
  logic       next_sdaPrev;

  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       byteDone;
  logic       wrEn;
  logic [7:0] rdData;
  logic       sharedRailPg;
  logic [7:0] outOnePgIn;
  logic [7:0] outFourPgIn;

  // line events; pins are taken as synchronous, one stage of history suffices
  assign sclRise   = sclIn & ~sclPrev;
  assign sclFall   = ~sclIn & sclPrev;
  assign startSeen = sclIn & sclPrev & sdaPrev & ~sdaIn;
  assign stopSeen  = sclIn & sclPrev & ~sdaPrev & sdaIn;
  assign byteDone  = (bitCnt == BYTE_BITS);

  // open drain: the line is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaDrive;

  // a data byte is committed on the falling clock after its eighth bit
  assign wrEn = (state == ST_WRITE) && sclFall && byteDone; // [RULE_18]

  always_comb begin
    next_sclPrev = sclIn;
    next_sdaPrev = sdaIn;
  end

  // history resets to the idle level of both lines, so release shows no false edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= next_sclPrev;
      sdaPrev <= next_sdaPrev;
    end
  end

  always_comb begin
    next_state     = state;
    next_bitCnt    = bitCnt;
    next_rxShift   = rxShift;
    next_txShift   = txShift;
    next_regPtr    = regPtr;
    next_sdaDrive  = sdaDrive;
    next_masterAck = masterAck;
    if (stopSeen) begin
      next_state    = ST_IDLE;
      next_sdaDrive = 1'b0;
    end else if (startSeen) begin
      // a repeated start keeps the register pointer for a following read
      next_state    = ST_ADDR;
      next_bitCnt   = CNT_ZERO;
      next_sdaDrive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sdaDrive = 1'b0;
        end
        ST_ADDR, ST_REG, ST_WRITE: begin
          if (sclRise && !byteDone) begin
            next_rxShift = {rxShift[6:0], sdaIn};
            next_bitCnt  = bitCnt + CNT_ONE;
          end else if (sclFall && byteDone) begin
            next_bitCnt = CNT_ZERO;
            if (state == ST_ADDR) begin
              if (rxShift[7:1] == DEV_ADDR) begin
                next_state     = ST_ADDR_ACK;
                next_sdaDrive  = 1'b1;
                next_masterAck = rxShift[0];
              end else begin
                // another target is addressed; stay off the line
                next_state = ST_IDLE;
              end
            end else if (state == ST_REG) begin
              next_state    = ST_REG_ACK;
              next_regPtr   = rxShift;
              next_sdaDrive = 1'b1;
            end else begin
              next_state    = ST_WRITE_ACK;
              next_regPtr   = regPtr + PTR_STEP;
              next_sdaDrive = 1'b1;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            next_bitCnt = CNT_ZERO;
            if (masterAck) begin
              next_state    = ST_READ;
              next_txShift  = rdData;
              next_sdaDrive = ~rdData[7];
            end else begin
              next_state    = ST_REG;
              next_sdaDrive = 1'b0;
            end
          end
        end
        ST_REG_ACK, ST_WRITE_ACK: begin
          if (sclFall) begin
            next_state    = ST_WRITE;
            next_bitCnt   = CNT_ZERO;
            next_sdaDrive = 1'b0;
          end
        end
        ST_READ: begin
          if (sclRise && !byteDone) begin
            next_bitCnt = bitCnt + CNT_ONE;
          end else if (sclFall && byteDone) begin
            // release so the controller can answer
            next_state    = ST_READ_ACK;
            next_regPtr   = regPtr + PTR_STEP;
            next_sdaDrive = 1'b0;
          end else if (sclFall) begin
            next_txShift  = {txShift[6:0], 1'b0};
            next_sdaDrive = ~txShift[6];
          end
        end
        ST_READ_ACK: begin
          if (sclRise) begin
            next_masterAck = ~sdaIn;
          end else if (sclFall) begin
            next_bitCnt = CNT_ZERO;
            if (masterAck) begin
              next_state    = ST_READ;
              next_txShift  = rdData;
              next_sdaDrive = ~rdData[7];
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state    = ST_IDLE;
          next_sdaDrive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      bitCnt    <= CNT_ZERO;
      rxShift   <= UNMAPPED_DATA;
      txShift   <= UNMAPPED_DATA;
      regPtr    <= UNMAPPED_DATA;
      sdaDrive  <= 1'b0;
      masterAck <= 1'b0;
    end else begin
      state     <= next_state;
      bitCnt    <= next_bitCnt;
      rxShift   <= next_rxShift;
      txShift   <= next_txShift;
      regPtr    <= next_regPtr;
      sdaDrive  <= next_sdaDrive;
      masterAck <= next_masterAck;
    end
  end

  pgm_mask_regs #(
    .OUT1_RESET (pgm_out1_reset(VARIANT)),
    .OUT4_RESET (pgm_out4_reset(VARIANT))
  ) u_regs (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .wrEn        (wrEn),
    .regAddr     (regPtr),
    .wrData      (rxShift),
    .rdData      (rdData),
    .outOneMask  (outOneMask),
    .outFourMask (outFourMask)
  );

  // the shared input is fixed by the factory variant, not by software
  assign sharedRailPg = (VARIANT == VARIANT_D) ? bLoadSwitchTwoPg
                                               : aLinearRegOnePg; // [RULE_06]

  always_comb begin
    outOnePgIn                  = UNMAPPED_DATA;
    outOnePgIn[BIT_CTRL_FIVE]   = controlInputFive;       // [RULE_01]
    outOnePgIn[BIT_CTRL_FOUR]   = controlInputFour;       // [RULE_02]
    outOnePgIn[BIT_CTRL_TWO]    = controlInputTwo;        // [RULE_03]
    outOnePgIn[BIT_CTRL_ONE]    = controlInputOne;        // [RULE_04]
    outOnePgIn[BIT_TERMINATION] = terminationRegulatorPg; // [RULE_05]
    outOnePgIn[BIT_SHARED_RAIL] = sharedRailPg;           // [RULE_06]
    outOnePgIn[BIT_B_SWITCH_1]  = bLoadSwitchOnePg;       // [RULE_07]
    outOnePgIn[BIT_A_LINREG_3]  = aLinearRegThreePg;      // [RULE_08]
  end

  always_comb begin
    outFourPgIn                  = UNMAPPED_DATA;
    outFourPgIn[BIT_A_LINREG_2]  = aLinearRegTwoPg;  // [RULE_09]
    outFourPgIn[BIT_A_SWITCH_1]  = aLoadSwitchOnePg; // [RULE_10]
    outFourPgIn[BIT_STEP_DOWN_6] = stepDownSixPg;    // [RULE_11]
    outFourPgIn[BIT_STEP_DOWN_5] = stepDownFivePg;   // [RULE_12]
    outFourPgIn[BIT_STEP_DOWN_4] = stepDownFourPg;   // [RULE_13]
    outFourPgIn[BIT_STEP_DOWN_3] = stepDownThreePg;  // [RULE_14]
    outFourPgIn[BIT_STEP_DOWN_2] = stepDownTwoPg;    // [RULE_15]
    outFourPgIn[BIT_STEP_DOWN_1] = stepDownOnePg;    // [RULE_16]
  end

  // these cover only the inputs that the two registers here govern
  pgm_pg_tree u_out_one (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pgIn    (outOnePgIn),
    .ignore  (outOneMask),
    .allGood (generalOutputOneGood)
  );

  pgm_pg_tree u_out_four (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pgIn    (outFourPgIn),
    .ignore  (outFourMask),
    .allGood (generalOutputFourGood)
  );

endmodule

// ### src/pgm_pg_tree.sv
// one power-good combination: and of every input whose mask bit is clear
`timescale 1ns/10ps
module pgm_pg_tree (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // inputs and their ignore bits
  input  wire logic [7:0] pgIn,
  input  wire logic [7:0] ignore,
  // combined result
  output logic            allGood
);

  logic [7:0] term;
  logic       next_allGood;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_term
      assign term[i] = pgIn[i] | ignore[i]; // [RULE_17]
    end
  endgenerate

  always_comb begin
    next_allGood = &term; // [RULE_17]
  end

  // not good while held in reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      allGood <= 1'b0;
    end else begin
      allGood <= next_allGood;
    end
  end

endmodule

// ### src/pgm_pkg.sv
// constants, types and reset tables for the power-good mask registers
package pgm_pkg;

  // register offsets on the serial control port
  localparam logic [7:0] OUT1_MASK_HI_ADDR = 8'hA5;
  localparam logic [7:0] OUT4_MASK_LO_ADDR = 8'hA6;

  // answer for an offset this block does not hold
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // output one, high mask register bit positions
  localparam int BIT_CTRL_FIVE   = 7;
  localparam int BIT_CTRL_FOUR   = 6;
  localparam int BIT_CTRL_TWO    = 5;
  localparam int BIT_CTRL_ONE    = 4;
  localparam int BIT_TERMINATION = 3;
  localparam int BIT_SHARED_RAIL = 2;
  localparam int BIT_B_SWITCH_1  = 1;
  localparam int BIT_A_LINREG_3  = 0;

  // output four, low mask register bit positions
  localparam int BIT_A_LINREG_2  = 7;
  localparam int BIT_A_SWITCH_1  = 6;
  localparam int BIT_STEP_DOWN_6 = 5;
  localparam int BIT_STEP_DOWN_5 = 4;
  localparam int BIT_STEP_DOWN_4 = 3;
  localparam int BIT_STEP_DOWN_3 = 2;
  localparam int BIT_STEP_DOWN_2 = 1;
  localparam int BIT_STEP_DOWN_1 = 0;

  // factory variants; variant D routes the second b-rail switch to the shared input
  typedef enum {VARIANT_A, VARIANT_B, VARIANT_C, VARIANT_D} pgm_variant_type;

  localparam logic [7:0] OUT1_RST_A = 8'hFF;
  localparam logic [7:0] OUT1_RST_B = 8'hEB;
  localparam logic [7:0] OUT1_RST_C = 8'hFF;
  localparam logic [7:0] OUT1_RST_D = 8'hEF;
  localparam logic [7:0] OUT4_RST_A = 8'hF7;
  localparam logic [7:0] OUT4_RST_B = 8'hBF;
  localparam logic [7:0] OUT4_RST_C = 8'hF7;
  localparam logic [7:0] OUT4_RST_D = 8'hFF;

  // serial target address; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5E;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  localparam logic [7:0] PTR_STEP  = 8'h01;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
  } pgm_i2c_state_type;

  function automatic logic [7:0] pgm_out1_reset(pgm_variant_type v);
    case (v)
      VARIANT_A: return OUT1_RST_A;
      VARIANT_B: return OUT1_RST_B;
      VARIANT_C: return OUT1_RST_C;
      default:   return OUT1_RST_D;
    endcase
  endfunction

  function automatic logic [7:0] pgm_out4_reset(pgm_variant_type v);
    case (v)
      VARIANT_A: return OUT4_RST_A;
      VARIANT_B: return OUT4_RST_B;
      VARIANT_C: return OUT4_RST_C;
      default:   return OUT4_RST_D;
    endcase
  endfunction

endpackage
